// ### core/dcr_port.sv
`timescale 1ns/1ps
module dcr_port
   import dcr_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [1:0] addrSel,
   input wire logic [1:0] zeroDetect,
   output logic [7:0] leftAttenuation,
   output logic [7:0] rightAttenuation,
   output logic [7:0] fmtCtrl,
   output logic [7:0] rampCtrl,
   output logic [7:0] modeCtrl,
   output logic [7:0] zeroOutputEn,
   output logic leftMute,
   output logic rightMute
);
   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_INDEX, ST_WDATA,
      ST_RDATA, ST_RACK, ST_SKIP} dcr_state_e;

   // link-side reset: level crossing of nrst
   logic lrs1_q, lrst_q;
   always_ff @(posedge linkClk) begin
      lrs1_q <= nrst;
      lrst_q <= lrs1_q;
   end

   // pin sync then all-samples-equal filter; link clock period 15 ns
   logic [1:0] s1_q, s2_q;
   // strap pins are static but still pass two flops
   logic [1:0] as1_q, as2_q;
   logic [FILT_LEN-1:0] sclSh_q, sdaSh_q;
   logic sclF_q, sdaF_q, sclP_q, sdaP_q;
   always_ff @(posedge linkClk) begin
      s1_q <= {sclIn, sdaIn};
      s2_q <= s1_q;
      as1_q <= addrSel;
      as2_q <= as1_q;
   end
   always_ff @(posedge linkClk) begin
      if (!lrst_q) begin
         sclSh_q <= '1;
         sdaSh_q <= '1;
         sclF_q <= 1'b1;
         sdaF_q <= 1'b1;
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclSh_q <= {sclSh_q[FILT_LEN-2:0], s2_q[1]};
         sdaSh_q <= {sdaSh_q[FILT_LEN-2:0], s2_q[0]};
         // level changes only after FILT_LEN equal samples
         if (&sclSh_q) sclF_q <= 1'b1;
         else if (~|sclSh_q) sclF_q <= 1'b0;
         if (&sdaSh_q) sdaF_q <= 1'b1;
         else if (~|sdaSh_q) sdaF_q <= 1'b0;
         sclP_q <= sclF_q;
         sdaP_q <= sdaF_q;
      end
   end
   wire startC = sclF_q && sclP_q && sdaP_q && !sdaF_q;
   wire stopC = sclF_q && sclP_q && !sdaP_q && sdaF_q;
   wire sclRise = sclF_q && !sclP_q;
   wire sclFall = !sclF_q && sclP_q;

   // register file, link domain
   logic [7:0] regL_q, regR_q, regF_q, regT_q, regM_q, regZ_q;
   logic [1:0] zs1_q, zs2_q;
   always_ff @(posedge linkClk) begin
      zs1_q <= zeroDetect;
      zs2_q <= zs1_q;
   end

   dcr_state_e st_q;
   logic [7:0] sh_q;
   logic [3:0] bit_q;
   logic [6:0] idx_q;
   logic rd_q, wrote_q, ackOk_q, nack_q, oe_q, first_q;
   logic updTgl_q;
   logic [7:0] rdByte;

   assign rdByte = (idx_q == ADDR_LEFT_ATT) ? regL_q :
      (idx_q == ADDR_RIGHT_ATT) ? regR_q :
      (idx_q == ADDR_FMT_CTRL) ? regF_q :
      (idx_q == ADDR_RAMP_CTRL) ? regT_q :
      (idx_q == ADDR_MODE_CTRL) ? regM_q :
      (idx_q == ADDR_ZERO_EN) ? regZ_q :
      (idx_q == ADDR_ZERO_FLAGS) ? {6'h00, zs2_q} :
      (idx_q == ADDR_DEV_NUM) ? {3'h0, DEV_NUM_DEF} :
      UNDEF_READ;

   wire writable = idx_q >= ADDR_LEFT_ATT && idx_q <= ADDR_ZERO_EN;
   wire addrHit = sh_q[7:1] == {BUS_ADDR_TOP[6:2], as2_q};
   wire [6:0] idxInc = (idx_q == IDX_WRAP) ? 7'h00 : idx_q + 7'h01;

   always_ff @(posedge linkClk) begin
      if (!lrst_q) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         idx_q <= 7'h00;
         rd_q <= 1'b0;
         wrote_q <= 1'b0;
         ackOk_q <= 1'b0;
         nack_q <= 1'b0;
         oe_q <= 1'b0;
         first_q <= 1'b0;
         updTgl_q <= 1'b0;
         regL_q <= RST_ATT;
         regR_q <= RST_ATT;
         regF_q <= RST_FMT;
         regT_q <= RST_RAMP;
         regM_q <= RST_MODE;
         regZ_q <= RST_ZERO_EN;
      end else if (startC) begin
         st_q <= ST_ADDR;
         bit_q <= 4'h0;
         oe_q <= 1'b0;
      end else if (stopC) begin
         st_q <= ST_IDLE;
         oe_q <= 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_INDEX, ST_WDATA: begin
               if (sclRise) begin
                  sh_q <= {sh_q[6:0], sdaF_q};
                  bit_q <= bit_q + 4'h1;
               end
               if (sclFall && bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  if (st_q == ST_ADDR) begin
                     ackOk_q <= addrHit;
                     rd_q <= sh_q[0];
                     first_q <= 1'b1;
                  end else if (st_q == ST_INDEX) begin
                     ackOk_q <= 1'b1;
                     idx_q <= sh_q[6:0];
                     wrote_q <= 1'b0;
                  end else begin
                     ackOk_q <= writable;
                     if (writable) begin
                        wrote_q <= 1'b1;
                        idx_q <= idxInc;
                        updTgl_q <= !updTgl_q;
                     end
                     if (idx_q == ADDR_LEFT_ATT) regL_q <= sh_q;
                     if (idx_q == ADDR_RIGHT_ATT) regR_q <= sh_q;
                     if (idx_q == ADDR_FMT_CTRL)
                        regF_q <= sh_q & MASK_FMT;
                     if (idx_q == ADDR_RAMP_CTRL)
                        regT_q <= sh_q & MASK_RAMP;
                     if (idx_q == ADDR_MODE_CTRL)
                        regM_q <= sh_q & MASK_MODE;
                     if (idx_q == ADDR_ZERO_EN)
                        regZ_q <= sh_q & MASK_ZERO_EN;
                  end
                  st_q <= ST_ACK;
                  oe_q <= (st_q == ST_ADDR) ? addrHit : (st_q == ST_INDEX
                     || writable);
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  oe_q <= 1'b0;
                  if (!ackOk_q) st_q <= ST_SKIP;
                  else if (first_q && rd_q) begin
                     first_q <= 1'b0;
                     // index stepped back one after write, else it was just loaded
                     if (wrote_q) idx_q <= idx_q - 7'h01;
                     sh_q <= wrote_q ? 8'h00 : rdByte;
                     st_q <= ST_RDATA;
                     bit_q <= wrote_q ? 4'hF : 4'h0;
                  end else if (first_q) begin
                     first_q <= 1'b0;
                     st_q <= ST_INDEX;
                  end else st_q <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               // one-cycle reload after restoring index
               if (bit_q == 4'hF) begin
                  sh_q <= rdByte;
                  bit_q <= 4'h0;
                  wrote_q <= 1'b0;
                  oe_q <= !rdByte[7];
               end else begin
                  oe_q <= !sh_q[7];
                  if (sclFall) begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7) begin
                        st_q <= ST_RACK;
                        idx_q <= idxInc;
                        oe_q <= 1'b0;
                     end
                  end
               end
            end
            ST_RACK: begin
               if (sclRise) nack_q <= sdaF_q;
               if (sclFall) begin
                  st_q <= nack_q ? ST_SKIP : ST_RDATA;
                  sh_q <= rdByte;
                  bit_q <= 4'h0;
                  oe_q <= !nack_q && !rdByte[7];
               end
            end
            default: oe_q <= 1'b0;
         endcase
      end
   end

   // toggle crossing: bytes settle well before the toggle lands,
   // so the image is never taken while a byte is changing
   logic [2:0] tg_q;
   logic [1:0] oeS_q;
   logic [47:0] x2_q;
   wire imgLoad = tg_q[2] ^ tg_q[1];
   always_ff @(posedge clk) begin
      tg_q <= {tg_q[1:0], updTgl_q};
      oeS_q <= {oeS_q[0], oe_q};
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         x2_q <= {RST_ATT, RST_ATT, RST_FMT, RST_RAMP, RST_MODE, RST_ZERO_EN};
      end else if (imgLoad) begin
         x2_q <= {regL_q, regR_q, regF_q, regT_q, regM_q, regZ_q};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         leftAttenuation <= RST_ATT;
         rightAttenuation <= RST_ATT;
         fmtCtrl <= RST_FMT;
         rampCtrl <= RST_RAMP;
         modeCtrl <= RST_MODE;
         zeroOutputEn <= RST_ZERO_EN;
         leftMute <= 1'b0;
         rightMute <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
      end else begin
         fmtCtrl <= x2_q[31:24];
         rampCtrl <= x2_q[23:16];
         modeCtrl <= x2_q[15:8];
         zeroOutputEn <= x2_q[7:0];
         // applied levels follow codes only while updates enabled
         if (x2_q[24 + UPD_BIT]) begin
            leftAttenuation <= x2_q[47:40];
            rightAttenuation <= x2_q[39:32];
         end
         leftMute <= leftAttenuation <= MUTE_CODE_MAX;
         rightMute <= rightAttenuation <= MUTE_CODE_MAX;
         sdaOut <= 1'b0;
         sdaOe <= oeS_q[1];
      end
   end

   update_hold_a: assert property (@(posedge clk)
      disable iff (!nrst)
      !x2_q[24 + UPD_BIT] |=> $stable(leftAttenuation))
      else $error("attenuation changed while update disabled");

   mute_code_a: assert property (@(posedge clk)
      disable iff (!nrst)
      leftAttenuation <= MUTE_CODE_MAX |=> leftMute)
      else $error("low left code did not mute");

   mute_clear_a: assert property (@(posedge clk)
      disable iff (!nrst)
      leftAttenuation > MUTE_CODE_MAX |=> !leftMute)
      else $error("audible left code muted");

   right_mute_a: assert property (@(posedge clk)
      disable iff (!nrst)
      rightAttenuation <= MUTE_CODE_MAX |=> rightMute)
      else $error("low right code did not mute");

   wrap_index_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_RDATA && idx_q == IDX_WRAP && sclFall && bit_q == 4'h7
      |=> idx_q == 7'h00)
      else $error("index did not wrap");

   reserved_zero_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      lrst_q |-> regT_q[3:2] == 2'b00 && regZ_q[7:3] == 5'h00 && !regM_q[7])
      else $error("reserved bits set");

   refuse_ack_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_WDATA && sclFall && bit_q == 4'h8 && !writable |=> !oe_q)
      else $error("write to undefined index acknowledged");

   start_addr_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      startC |=> st_q == ST_ADDR && bit_q == 4'h0)
      else $error("start did not open an address byte");

   stop_idle_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      stopC |=> st_q == ST_IDLE && !oe_q)
      else $error("stop did not release the bus");

   skip_quiet_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_SKIP |-> !oe_q)
      else $error("data line driven while ignoring the bus");

   addr_ack_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_ADDR && sclFall && bit_q == 4'h8 |=> oe_q == $past(addrHit))
      else $error("address acknowledge wrong");

   index_load_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_INDEX && sclFall && bit_q == 4'h8
      |=> idx_q == $past(sh_q[6:0]))
      else $error("index byte not stored");

   write_mark_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_WDATA && sclFall && bit_q == 4'h8 && writable |=> wrote_q)
      else $error("write not remembered");

   hold_index_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_ACK && sclFall && ackOk_q && first_q && rd_q && wrote_q
      |=> idx_q == $past(idx_q) - 7'h01)
      else $error("first read after write advanced the index");

   read_advance_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      st_q == ST_RDATA && sclFall && bit_q == 4'h7 && idx_q != IDX_WRAP
      |=> idx_q == $past(idx_q) + 7'h01)
      else $error("index did not advance after a read byte");

   // a change must agree with the oldest sample left in the shift register
   scl_filter_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      sclF_q != sclP_q |-> sclSh_q[FILT_LEN-1] == sclF_q)
      else $error("clock filter passed a short pulse");

   sda_filter_a: assert property (@(posedge linkClk)
      disable iff (!lrst_q)
      sdaF_q != sdaP_q |-> sdaSh_q[FILT_LEN-1] == sdaF_q)
      else $error("data filter passed a short pulse");
endmodule

// ### core/dcr_pkg.sv
package dcr_pkg;
   localparam logic [6:0] ADDR_LEFT_ATT = 7'h10;
   localparam logic [6:0] ADDR_RIGHT_ATT = 7'h11;
   localparam logic [6:0] ADDR_FMT_CTRL = 7'h12;
   localparam logic [6:0] ADDR_RAMP_CTRL = 7'h13;
   localparam logic [6:0] ADDR_MODE_CTRL = 7'h14;
   localparam logic [6:0] ADDR_ZERO_EN = 7'h15;
   localparam logic [6:0] ADDR_ZERO_FLAGS = 7'h16;
   localparam logic [6:0] ADDR_DEV_NUM = 7'h17;
   localparam logic [6:0] IDX_WRAP = 7'h7F;
   localparam logic [7:0] RST_ATT = 8'hFF;
   localparam logic [7:0] RST_FMT = 8'h50;
   localparam logic [7:0] RST_RAMP = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_ZERO_EN = 8'h01;
   localparam logic [7:0] MASK_FMT = 8'hFF;
   localparam logic [7:0] MASK_RAMP = 8'hF3;
   localparam logic [7:0] MASK_MODE = 8'h7F;
   localparam logic [7:0] MASK_ZERO_EN = 8'h07;
   localparam logic [7:0] UNDEF_READ = 8'h00;
   localparam logic [7:0] MUTE_CODE_MAX = 8'h0E;
   localparam int UPD_BIT = 7;
   localparam int FMT_LSB = 4;
   localparam int RATE_LSB = 2;
   localparam int DEEMPH_BIT = 1;
   localparam int MUTE_BIT = 0;
   localparam int INV_BIT = 7;
   localparam int RAMP_LSB = 5;
   localparam int ODIS_BIT = 4;
   localparam int ROLL_BIT = 1;
   localparam int ZHOLD_BIT = 0;
   localparam int SOFT_RESET_BIT = 6;
   localparam int BSTR_BIT = 5;
   localparam int BYP_BIT = 4;
   localparam int MONO_BIT = 3;
   localparam int CHAN_BIT = 2;
   localparam int OSR_LSB = 0;
   localparam int SPIKE_NS = 50;
   localparam int LINK_NS = 15;
   localparam int FILT_LEN = (SPIKE_NS + LINK_NS - 1) / LINK_NS + 1;
   localparam logic [6:0] BUS_ADDR_TOP = 7'h00;
   localparam logic [4:0] DEV_NUM_DEF = 5'h05; // arbitrary value
endpackage

// ### test/dcr_master.sv
`timescale 1ns/1ps
module dcr_master (
   input wire logic clk,
   input wire logic sdaOe,
   input wire logic sdaOut,
   output logic scl,
   output logic sda,
   output logic resStb,
   output logic [8:0] resVal
);
   logic mSda = 1'b1, busy = 1'b0, glitchOn = 1'b0;
   // pull-up: a released line reads high
   assign sda = mSda & (sdaOe ? sdaOut : 1'b1);
   initial begin
      scl = 1'b1;
      resStb = 1'b0;
      resVal = 9'h000;
   end
   task automatic ph(input logic c, input logic d, input int n);
      scl <= c;
      mSda <= d;
      repeat (n) @(posedge clk);
   endtask
   // 1.3 us low, 0.7 us high, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      ph(1'b0, mSda, 30);
      ph(1'b0, b, 100);
      ph(1'b1, b, 35);
      s = sda;
      // 30 ns spike, under the suppressed width
      if (glitchOn) ph(1'b0, b, 3);
      ph(1'b1, b, 32);
   endtask
   task automatic start();
      if (busy) begin
         ph(1'b0, mSda, 30);
         ph(1'b0, 1'b1, 100);
         ph(1'b1, 1'b1, 70);
      end
      ph(1'b1, 1'b0, 70);
      busy = 1'b1;
   endtask
   task automatic stop();
      ph(1'b0, mSda, 30);
      ph(1'b0, 1'b0, 100);
      ph(1'b1, 1'b0, 70);
      ph(1'b1, 1'b1, 150);
      busy = 1'b0;
   endtask
   // rd releases sda for 8 bits, then acks or nacks the last byte
   task automatic xfer(input logic [7:0] b, input logic rd, input logic last);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(rd | b[i], s);
         d[i] = s;
      end
      bit_io(!rd | last, s);
      resVal <= rd ? {1'b1, d} : {8'h00, !s};
      resStb <= 1'b1;
      ph(scl, mSda, 1);
      resStb <= 1'b0;
   endtask
endmodule

// ### test/dcr_port_tb.sv
`timescale 1ns/1ps
module dcr_port_tb
   import dcr_pkg::*;
;
   localparam logic [6:0] DEV = {BUS_ADDR_TOP[6:2], 2'b10};
   logic clk, linkClk, nrst, scl, sda, sdaOut, sdaOe, lMute, rMute, resStb;
   logic [1:0] addrSel, zeroDetect;
   logic [7:0] lAtt, rAtt, fmt, ramp, mode, zen, r0, r1, r2;
   logic [8:0] resVal;
   logic [8:0] expQ[$];
   logic [31:0] lfsrQ = 32'h014A;
   int badCount = 0, testsRun = 0;
   dcr_port u_dcr_port (
      .clk(clk), .nrst(nrst), .linkClk(linkClk), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
      .zeroDetect(zeroDetect), .leftAttenuation(lAtt),
      .rightAttenuation(rAtt), .fmtCtrl(fmt), .rampCtrl(ramp),
      .modeCtrl(mode), .zeroOutputEn(zen), .leftMute(lMute),
      .rightMute(rMute)
   );
   dcr_master u_dcr_master (
      .clk(clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sda(sda),
      .resStb(resStb), .resVal(resVal)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      linkClk = 1'b0;
      #3.7;
      forever #7.5 linkClk = ~linkClk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_bus(input logic [8:0] e, input logic [8:0] g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("[ERR] bus result exp %h got %h", e, g);
      end
   endtask
   task automatic cmp_port(input string n, input logic [7:0] e,
                           input logic [7:0] g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      if (badCount == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // results come back in order, so the oldest note is theirs
   always @(posedge clk) begin
      if (resStb === 1'b1)
         cmp_bus(expQ.size() > 0 ? expQ.pop_front() : 'x, resVal);
   end
   task automatic ack(input logic a);
      expQ.push_back({8'h00, a});
   endtask
   task automatic sel(input logic [6:0] idx, input logic ok);
      u_dcr_master.start();
      ack(1'b1);
      u_dcr_master.xfer({DEV, 1'b0}, 1'b0, 1'b0);
      ack(ok);
      u_dcr_master.xfer({1'b0, idx}, 1'b0, 1'b0);
   endtask
   task automatic wr(input logic [7:0] d);
      ack(1'b1);
      u_dcr_master.xfer(d, 1'b0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] e[$]);
      u_dcr_master.start();
      ack(1'b1);
      u_dcr_master.xfer({DEV, 1'b1}, 1'b0, 1'b0);
      foreach (e[i]) begin
         expQ.push_back({1'b1, e[i]});
         u_dcr_master.xfer(8'hFF, 1'b1, i == e.size() - 1);
      end
      u_dcr_master.stop();
   endtask
   // whole run needs about 76k cycles
   initial begin
      repeat (90000) @(posedge clk);
      badCount++;
      report_and_stop();
   end
   initial begin
      repeat (9) lfsrQ = lfsr(lfsrQ);
      nrst <= 1'b0;
      addrSel <= DEV[1:0];
      zeroDetect <= lfsrQ[1:0];
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (20) @(posedge clk);
      cmp_port("left att", RST_ATT, lAtt);
      cmp_port("right att", RST_ATT, rAtt);
      cmp_port("fmt", RST_FMT, fmt);
      cmp_port("ramp", RST_RAMP, ramp);
      cmp_port("mode", RST_MODE, mode);
      cmp_port("zero en", RST_ZERO_EN, zen);
      sel(ADDR_FMT_CTRL, 1'b1);
      rd('{RST_FMT, RST_RAMP, RST_MODE, RST_ZERO_EN});
      sel(ADDR_LEFT_ATT, 1'b1);
      wr(8'h0E);
      wr(8'h0F);
      rd('{8'h0F, RST_FMT});
      cmp_port("held att", RST_ATT, lAtt);
      u_dcr_master.glitchOn = 1'b1;
      sel(ADDR_FMT_CTRL, 1'b1);
      wr(8'hD0);
      u_dcr_master.stop();
      sel(ADDR_LEFT_ATT, 1'b1);
      wr(8'h0E);
      wr(8'h0F);
      u_dcr_master.stop();
      u_dcr_master.glitchOn = 1'b0;
      cmp_port("fmt", 8'hD0, fmt);
      cmp_port("left att", 8'h0E, lAtt);
      cmp_port("left mute", 8'h01, {7'h00, lMute});
      cmp_port("right mute", 8'h00, {7'h00, rMute});
      // index of a read-only byte is taken, the data byte is refused
      sel(ADDR_ZERO_FLAGS, 1'b1);
      ack(1'b0);
      u_dcr_master.xfer(8'hA5, 1'b0, 1'b0);
      u_dcr_master.stop();
      sel(IDX_WRAP, 1'b1);
      rd('{UNDEF_READ, UNDEF_READ});
      u_dcr_master.start();
      ack(1'b0);
      u_dcr_master.xfer({DEV ^ 7'h01, 1'b0}, 1'b0, 1'b0);
      u_dcr_master.stop();
      r0 = lfsrQ[7:0];
      // soft reset kept clear; the port only stores it in the mode byte
      r1 = lfsrQ[15:8] & 8'hBF;
      r2 = lfsrQ[23:16];
      sel(ADDR_RAMP_CTRL, 1'b1);
      wr(r0);
      wr(r1);
      wr(r2);
      rd('{r2 & MASK_ZERO_EN, {6'h00, zeroDetect},
           {3'h0, DEV_NUM_DEF}, UNDEF_READ});
      cmp_port("ramp", r0 & MASK_RAMP, ramp);
      cmp_port("mode", r1 & MASK_MODE, mode);
      cmp_port("zero en", r2 & MASK_ZERO_EN, zen);
      repeat (10) @(posedge clk);
      report_and_stop();
   end
endmodule
